// ### ingress_mac_model.sv
/* ingress mac and address-resolution model: one header descriptor per call.
   assumes a rising-edge clk_sys_in shared with the filter. */
`timescale 1ns/10ps
`default_nettype none
module ingress_mac_model (
    // clock
    input  wire logic        clk_sys_in,
    // descriptor
    output logic             frm_valid_out,
    output logic [2:0]       frm_port_out,
    output logic [1:0]       frm_tag_count_out,
    output logic [15:0]      frm_outer_tag_protocol_identifier_out,
    output logic [15:0]      frm_outer_tci_out,
    output logic [15:0]      frm_inner_tci_out,
    output logic             frm_control_out,
    output logic [5:0]       arl_fwd_vec_out
);
    initial begin
        {frm_valid_out, frm_port_out, frm_tag_count_out, frm_outer_tag_protocol_identifier_out} = '0;
        {frm_outer_tci_out, frm_inner_tci_out, frm_control_out, arl_fwd_vec_out} = '0;
    end
    // callers keep customer ports to at most one tag
    task automatic send(input logic [2:0] p, input logic [1:0] n,
                        input logic [15:0] tp, tc, input logic c, input logic [5:0] v);
        @(posedge clk_sys_in);
        frm_valid_out <= 1'b1;
        {frm_port_out, frm_tag_count_out, frm_outer_tag_protocol_identifier_out} <= {p, n, tp};
        {frm_outer_tci_out, frm_inner_tci_out} <= {tc, tc ^ 16'h0FFF};
        {frm_control_out, arl_fwd_vec_out} <= {c, v};
        @(posedge clk_sys_in);
        frm_valid_out <= 1'b0;
        // released fields go stale, not held, except the inner TCI which keeps its value
        {frm_port_out, frm_tag_count_out, frm_outer_tag_protocol_identifier_out} <= ~{p, n, tp};
        {frm_outer_tci_out, frm_control_out, arl_fwd_vec_out} <= ~{tc, c, v};
    endtask : send
endmodule : ingress_mac_model
`default_nettype wire

// ### test_vlan_double_tag_filter.sv
/* testbench for the vlan filter: register tasks and frame cases with
   expected results. assumes ingress_mac_model drives the descriptors. */
`timescale 1ns/10ps
`default_nettype none
module test_vlan_double_tag_filter;
    import vlan_dtag_pkg::*;
    logic        clk_sys_in, rst_n_in, reg_wr_in, reg_rd_in, frm_valid_in, frm_control_in;
    logic [7:0]  reg_addr_in;
    logic [31:0] reg_wdata_in, reg_rdata_out, rd_v;
    logic [2:0]  frm_port_in, traffic_class_out;
    logic [1:0]  frm_tag_count_in;
    logic [15:0] frm_outer_tag_protocol_identifier_in, frm_outer_tci_in, frm_inner_tci_in;
    logic [15:0] res_isp_tci_out, res_cust_tci_out;
    logic [5:0]  arl_fwd_vec_in, res_dest_vec_out, res_untag_vec_out;
    logic [11:0] res_vlan_id_out;
    logic        res_valid_out, res_insert_isp_out, res_insert_cust_out, res_fcs_regen_out;
    int          n_mismatch, checks_done, cyc;
    vlan_double_tag_filter vlan_double_tag_filter_i (.clk_sys_in, .rst_n_in, .reg_addr_in,
        .reg_wdata_in, .reg_wr_in, .reg_rd_in, .reg_rdata_out, .frm_valid_in, .frm_port_in,
        .frm_tag_count_in, .frm_outer_tag_protocol_identifier_in, .frm_outer_tci_in, .frm_inner_tci_in,
        .frm_control_in, .arl_fwd_vec_in, .res_valid_out, .res_dest_vec_out,
        .res_untag_vec_out, .res_vlan_id_out, .traffic_class_out, .res_insert_isp_out,
        .res_insert_cust_out, .res_isp_tci_out, .res_cust_tci_out, .res_fcs_regen_out);
    ingress_mac_model ingress_mac_model_i (.clk_sys_in, .frm_valid_out(frm_valid_in),
        .frm_port_out(frm_port_in), .frm_tag_count_out(frm_tag_count_in),
        .frm_outer_tag_protocol_identifier_out(frm_outer_tag_protocol_identifier_in), .frm_outer_tci_out(frm_outer_tci_in),
        .frm_inner_tci_out(frm_inner_tci_in), .frm_control_out(frm_control_in),
        .arl_fwd_vec_out(arl_fwd_vec_in));
    initial begin
        clk_sys_in = 1'b0;
        forever #4 clk_sys_in = ~clk_sys_in;
    end
    task automatic final_report();
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : final_report
    // a hang is cut short well past the expected length of the run
    always @(posedge clk_sys_in) begin
        cyc++;
        if (cyc == 5000) begin
            n_mismatch++;
            final_report();
        end
    end
    task automatic chk(input string nm, input logic [31:0] s, e);
        checks_done++;
        if (s !== e) begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", nm, e, s);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys_in);
        {reg_wr_in, reg_addr_in, reg_wdata_in} <= {1'b1, a, d};
        @(posedge clk_sys_in);
        reg_wr_in <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a);
        @(posedge clk_sys_in);
        {reg_rd_in, reg_addr_in} <= {1'b1, a};
        @(posedge clk_sys_in);
        reg_rd_in <= 1'b0;
        #1 rd_v = reg_rdata_out;
    endtask : rd
    // result stands in the second cycle after the taking edge
    task automatic go(input logic [2:0] p, input logic [1:0] n,
                      input logic [15:0] tp, tc, input logic c, input logic [5:0] v);
        ingress_mac_model_i.send(p, n, tp, tc, c, v);
        @(posedge clk_sys_in);
        #1 chk("valid", 32'(res_valid_out), 32'h1);
    endtask : go
    initial begin
        {reg_wr_in, reg_rd_in, reg_addr_in, reg_wdata_in} = '0;
        rst_n_in = 1'b0;
        repeat (8) @(posedge clk_sys_in);
        rst_n_in <= 1'b1;
        rd(REG_ISP_TAG_PROTOCOL_IDENTIFIER);
        chk("isp tag_protocol_identifier", rd_v, 32'h0000_9100);
        rd(REG_PORT_BASE);
        chk("port cfg", rd_v, 32'h003F_0001);
        rd(8'hFC);
        chk("unmapped", rd_v, 32'h0);
        wr(REG_PORT_BASE + 8'h04, 32'h0006_0001);
        // the table is not cleared by reset: program the entry for port default VID 1
        wr(REG_VT_INDEX, 32'h001);
        wr(REG_VT_DATA, 32'h0000_003F);
        wr(REG_GLOBAL, 32'h04);
        go(3'h1, 2'h0, 16'h0, 16'h0, 1'b0, 6'h3F);
        chk("mask", 32'(res_dest_vec_out), 32'h06);
        chk("no dt", 32'(res_insert_isp_out), 32'h0);
        wr(REG_VT_INDEX, 32'h123);
        wr(REG_VT_DATA, 32'h0001_0A15); // isp port 0 never stripped
        rd(REG_VT_DATA);
        chk("entry", rd_v, 32'h0001_0A15);
        wr(REG_VT_INDEX, 32'h0AB);
        wr(REG_VT_DATA, 32'h0000_003F);
        wr(REG_ISP_PORTS, 32'h01);
        wr(REG_PORT_BASE + 8'h08, 32'h003F_00AB);
        wr(REG_GLOBAL, 32'h84);
        go(3'h2, 2'h0, 16'h0, 16'h0, 1'b0, 6'h3F);
        chk("ins", 32'({res_insert_isp_out, res_insert_cust_out}), 32'h3);
        chk("vid", 32'(res_vlan_id_out), 32'h0AB);
        chk("isp tci", 32'(res_isp_tci_out), 32'h00AB);
        chk("fcs", 32'(res_fcs_regen_out), 32'h1);
        go(3'h2, 2'h1, TAG_PROTOCOL_IDENTIFIER_CUST, 16'hA055, 1'b0, 6'h3F);
        chk("ins", 32'({res_insert_isp_out, res_insert_cust_out}), 32'h2);
        chk("class", 32'(traffic_class_out), 32'h5);
        chk("isp tci", 32'(res_isp_tci_out), 32'hA0AB);
        go(3'h2, 2'h1, TAG_PROTOCOL_IDENTIFIER_CUST, 16'h6000, 1'b0, 6'h3F);
        chk("prio tci", 32'(res_cust_tci_out), 32'h60AB);
        go(3'h0, 2'h1, TAG_PROTOCOL_IDENTIFIER_ISP_RST, 16'hC123, 1'b0, 6'h01);
        chk("ins", 32'({res_insert_isp_out, res_insert_cust_out}), 32'h1);
        chk("cust vid", 32'(res_cust_tci_out[11:0]), 32'h001);
        chk("isp vid", 32'(res_vlan_id_out), 32'h123);
        chk("member", 32'(res_dest_vec_out), 32'h15);
        chk("untag", 32'(res_untag_vec_out), 32'h0A);
        go(3'h0, 2'h2, TAG_PROTOCOL_IDENTIFIER_ISP_RST, 16'hC123, 1'b0, 6'h01);
        chk("as is", 32'({res_insert_isp_out, res_insert_cust_out, res_fcs_regen_out}), 32'h0);
        go(3'h0, 2'h1, TAG_PROTOCOL_IDENTIFIER_CUST, 16'h2055, 1'b0, 6'h01);
        chk("ins", 32'({res_insert_isp_out, res_insert_cust_out}), 32'h3);
        chk("port_default_vlan_id", 32'(res_vlan_id_out), 32'h001);
        chk("isp tci", 32'(res_isp_tci_out), 32'h2001);
        chk("dest", 32'(res_dest_vec_out), 32'h01);
        wr(REG_VT_INDEX, 32'h123);
        wr(REG_VT_DATA, 32'h0001_2A35);
        wr(REG_GLOBAL, 32'h85);
        go(3'h0, 2'h2, TAG_PROTOCOL_IDENTIFIER_ISP_RST, 16'hC123, 1'b0, 6'h01);
        chk("mgmt tag", 32'(res_untag_vec_out), 32'h0A);
        go(3'h2, 2'h0, 16'h0, 16'h0, 1'b1, 6'h01);
        chk("ctrl", 32'(res_dest_vec_out), 32'h20);
        wr(REG_GLOBAL, 32'h94);
        go(3'h0, 2'h2, TAG_PROTOCOL_IDENTIFIER_ISP_RST, 16'hC123, 1'b0, 6'h0E);
        chk("pvlan", 32'(res_dest_vec_out), 32'h0E);
        // a reprogrammed identifier must now qualify the outer tag
        wr(REG_ISP_TAG_PROTOCOL_IDENTIFIER, 32'h0000_88A8);
        go(3'h0, 2'h1, 16'h88A8, 16'hC123, 1'b0, 6'h01);
        chk("new tag_protocol_identifier", 32'({res_insert_isp_out, res_insert_cust_out}), 32'h1);
        rd(REG_FRM_COUNT);
        chk("frames", rd_v, 32'h0000_000B);
        final_report();
    end
endmodule : test_vlan_double_tag_filter
`default_nettype wire

// ### vlan_double_tag_filter.sv
/*
 * VLAN filter and double-tag normaliser. Takes one frame header
 * descriptor per cycle with the address-resolution vector and returns,
 * two cycles later, the egress port set, per-port untag set, lookup VID,
 * traffic class and the tag insertions to apply.
 * Assumes the MAC side presents parsed tags and the editor downstream
 * applies the insertions and rebuilds the check sequence when told.
 */
// Our own choices: the placing of the registers and the strobed register port.
// Operation
// - destination vector is ANDed with the ingress port's permitted-port mask, except control frames sent to the processor port.
// - internal 4096-entry VLAN table looked up for every frame, no processor.
// - each entry's untag bitmap decides tag strip or keep per egress port.
// - each entry holds a one-bit-per-port membership bitmap.
// - entry flag chooses membership or address-resolution vector as destination.
// - management port keeps its tag even when its untag bit is set.
// - double tagging only when mode field nonzero and 802.1Q enabled.
// - double-tag mode looks up by ISP VID; customer tag is the 802.1Q tag.
// - ISP tags are qualified by one programmable identifier, reset 9100.
// - double tagging normalises every frame to two tags; matching doubles untouched.
// - per-port bitmap marks ISP-facing ports; several may be set.
// - ISP port, untagged or mismatched outer: insert both tags, ISP VID is PORT_DEFAULT_VLAN_ID.
// - enabled port-based VLAN overrides the table's egress selection, in double-tag mode only.
// - ISP port, ISP-tagged frame gains customer tag 8100 with PORT_DEFAULT_VLAN_ID.
// - flag set on ISP port forwards straight to the membership bitmap.
// - VID comes from the ISP tag, class from received outer tag.
// - customer port inserts ISP tag or both, ISP VID from PORT_DEFAULT_VLAN_ID.
// - priority-only tag has VID replaced by PORT_DEFAULT_VLAN_ID, class unchanged.
// - control frames go to processor port in management mode without flood, when double tagging is active.
`timescale 1ns/10ps
`default_nettype none
module vlan_double_tag_filter (
    // clock and reset
    input  wire logic                                clk_sys_in,
    input  wire logic                                rst_n_in,
    // register port
    input  wire logic [7:0]                          reg_addr_in,
    input  wire logic [31:0]                         reg_wdata_in,
    input  wire logic                                reg_wr_in,
    input  wire logic                                reg_rd_in,
    output logic      [31:0]                         reg_rdata_out,
    // ingress frame descriptor
    input  wire logic                                frm_valid_in,
    input  wire logic [vlan_dtag_pkg::PORT_W-1:0]    frm_port_in,
    input  wire logic [1:0]                          frm_tag_count_in,
    input  wire logic [15:0]                         frm_outer_tag_protocol_identifier_in,
    input  wire logic [15:0]                         frm_outer_tci_in,
    input  wire logic [15:0]                         frm_inner_tci_in,
    input  wire logic                                frm_control_in,
    input  wire logic [vlan_dtag_pkg::NPORT-1:0]     arl_fwd_vec_in,
    // forwarding result
    output logic                                     res_valid_out,
    output logic      [vlan_dtag_pkg::NPORT-1:0]     res_dest_vec_out,
    output logic      [vlan_dtag_pkg::NPORT-1:0]     res_untag_vec_out,
    output logic      [vlan_dtag_pkg::VID_W-1:0]     res_vlan_id_out,
    output logic      [2:0]                          traffic_class_out,
    output logic                                     res_insert_isp_out,
    output logic                                     res_insert_cust_out,
    output logic      [15:0]                         res_isp_tci_out,
    output logic      [15:0]                         res_cust_tci_out,
    output logic                                     res_fcs_regen_out
);
    import vlan_dtag_pkg::*;

    // ********************************************
    // configuration registers
    // ********************************************
    logic [7:0]         global_r;
    logic [15:0]        isp_tag_protocol_identifier_r;
    logic [NPORT-1:0]   isp_ports_r;
    logic [VID_W-1:0]   vt_index_r;
    logic [15:0]        frm_count_r;
    logic [VID_W-1:0]   port_default_vlan_id_r      [NPORT];
    logic [NPORT-1:0]   port_mask_r [NPORT];
    logic [ENTRY_W-1:0] vtable      [VT_DEPTH];

    logic               qtag_en;
    logic               dt_active;
    logic               mgmt_mode;
    logic               reserved_multicast_flood;
    logic               pvlan_en;
    logic [1:0]         dt_mode;

    assign qtag_en          = global_r[G_QEN];
    assign dt_mode          = global_r[G_DT_LO+1:G_DT_LO];
    assign dt_active        = qtag_en && (dt_mode != 2'h0);
    assign mgmt_mode        = global_r[G_MGMT];
    assign reserved_multicast_flood = global_r[G_RMFLOOD];
    assign pvlan_en         = global_r[G_PVLAN];

    always_ff @(posedge clk_sys_in) begin
        if (!rst_n_in) begin
            global_r    <= GLOBAL_RST;
            isp_tag_protocol_identifier_r  <= TAG_PROTOCOL_IDENTIFIER_ISP_RST;
            isp_ports_r <= '0;
            vt_index_r  <= '0;
        end else if (reg_wr_in) begin
            case (reg_addr_in)
                REG_GLOBAL:    global_r    <= reg_wdata_in[7:0];
                REG_ISP_TAG_PROTOCOL_IDENTIFIER:  isp_tag_protocol_identifier_r  <= reg_wdata_in[15:0];
                REG_ISP_PORTS: isp_ports_r <= reg_wdata_in[NPORT-1:0];
                REG_VT_INDEX:  vt_index_r  <= reg_wdata_in[VID_W-1:0];
                default: ;
            endcase
        end
    end

    // per-port default VID and permitted-port mask
    genvar gp;
    generate
        for (gp = 0; gp < NPORT; gp++) begin : g_port
            localparam logic [7:0] PADDR = REG_PORT_BASE + 8'(gp) * REG_PORT_STEP;
            always_ff @(posedge clk_sys_in) begin
                if (!rst_n_in) begin
                    port_default_vlan_id_r[gp]      <= PORT_DEFAULT_VLAN_ID_RST;
                    port_mask_r[gp] <= PORT_MASK_RST;
                end else if (reg_wr_in && reg_addr_in == PADDR) begin
                    port_default_vlan_id_r[gp]      <= reg_wdata_in[VID_W-1:0];
                    port_mask_r[gp] <= reg_wdata_in[PC_MASK_LO+NPORT-1:PC_MASK_LO];
                end
            end
        end
    endgenerate

    // table write: one entry per write of the data register at the index
    always_ff @(posedge clk_sys_in) begin
        if (reg_wr_in && reg_addr_in == REG_VT_DATA) begin
            vtable[vt_index_r] <= {reg_wdata_in[VD_FWD],
                                   reg_wdata_in[VD_UNTAG_LO+NPORT-1:VD_UNTAG_LO],
                                   reg_wdata_in[NPORT-1:0]};
        end
    end

    always_ff @(posedge clk_sys_in) begin
        if (!rst_n_in) begin
            frm_count_r <= '0;
        end else if (frm_valid_in) begin
            frm_count_r <= frm_count_r + 16'h0001;
        end
    end

    // ********************************************
    // register read, data in the following cycle
    // ********************************************
    logic [ENTRY_W-1:0] rd_entry;
    logic [31:0]        rd_port;

    assign rd_entry = vtable[vt_index_r];

    always_comb begin
        rd_port = 32'h0000_0000;
        for (int p = 0; p < NPORT; p++) begin
            if (reg_addr_in == REG_PORT_BASE + 8'(p) * REG_PORT_STEP) begin
                rd_port = {10'h000, port_mask_r[p], 4'h0, port_default_vlan_id_r[p]};
            end
        end
    end

    always_ff @(posedge clk_sys_in) begin
        if (!rst_n_in) begin
            reg_rdata_out <= '0;
        end else if (reg_rd_in) begin
            case (reg_addr_in)
                REG_GLOBAL:    reg_rdata_out <= {24'h000000, global_r};
                REG_ISP_TAG_PROTOCOL_IDENTIFIER:  reg_rdata_out <= {16'h0000, isp_tag_protocol_identifier_r};
                REG_ISP_PORTS: reg_rdata_out <= {26'h0000000, isp_ports_r};
                REG_VT_INDEX:  reg_rdata_out <= {20'h00000, vt_index_r};
                REG_VT_DATA:   reg_rdata_out <= {15'h0000, rd_entry[E_FWD], 2'h0,
                                                 rd_entry[E_FWD-1:E_UNTAG_LO], 2'h0,
                                                 rd_entry[NPORT-1:0]};
                REG_FRM_COUNT: reg_rdata_out <= {16'h0000, frm_count_r};
                default:       reg_rdata_out <= rd_port;
            endcase
        end else begin
            reg_rdata_out <= '0;
        end
    end

    // ********************************************
    // stage A: tag normalisation
    // ********************************************
    logic [VID_W-1:0] port_default_vlan_id_in;
    logic             is_isp_port;
    logic             outer_isp;
    logic [VID_W-1:0] outer_vid;
    logic [15:0]      cust_rx_tci;
    logic             ins_isp_nxt;
    logic             ins_cust_nxt;
    logic [15:0]      isp_tci_nxt;
    logic [15:0]      cust_tci_nxt;
    logic             vid_fix_nxt;
    logic [2:0]       tc_nxt;

    assign port_default_vlan_id_in     = port_default_vlan_id_r[frm_port_in];
    assign is_isp_port = isp_ports_r[frm_port_in];
    assign outer_isp   = (frm_tag_count_in != 2'h0) && (frm_outer_tag_protocol_identifier_in == isp_tag_protocol_identifier_r);
    assign outer_vid   = frm_outer_tci_in[VID_W-1:0];
    // class always from the outer tag as received, zero when untagged
    assign tc_nxt      = (frm_tag_count_in != 2'h0) ? frm_outer_tci_in[15:13] : 3'h0;

    always_comb begin
        ins_isp_nxt  = 1'b0;
        ins_cust_nxt = 1'b0;
        isp_tci_nxt  = 16'h0000;
        vid_fix_nxt  = 1'b0;
        cust_rx_tci  = (outer_isp) ? frm_inner_tci_in : frm_outer_tci_in;
        cust_tci_nxt = {4'h0, port_default_vlan_id_in};
        if (dt_active) begin
            if (outer_isp) begin
                isp_tci_nxt = frm_outer_tci_in;
                if (frm_tag_count_in == 2'h1) begin
                    ins_cust_nxt = 1'b1;
                end else begin
                    cust_tci_nxt = cust_rx_tci;
                end
            end else begin
                ins_isp_nxt = 1'b1;
                isp_tci_nxt = {tc_nxt, 1'b0, port_default_vlan_id_in};
                if (is_isp_port || frm_tag_count_in == 2'h0) begin
                    ins_cust_nxt = 1'b1;
                end else begin
                    cust_tci_nxt = cust_rx_tci;
                end
            end
            if (isp_tci_nxt[VID_W-1:0] == VID_PRIO) begin
                isp_tci_nxt[VID_W-1:0] = port_default_vlan_id_in;
                vid_fix_nxt            = 1'b1;
            end
            if (!ins_cust_nxt && cust_tci_nxt[VID_W-1:0] == VID_PRIO) begin
                cust_tci_nxt[VID_W-1:0] = port_default_vlan_id_in;
                vid_fix_nxt             = 1'b1;
            end
        end else if (frm_tag_count_in != 2'h0 && frm_outer_tag_protocol_identifier_in == TAG_PROTOCOL_IDENTIFIER_CUST) begin
            cust_tci_nxt = frm_outer_tci_in;
            if (outer_vid == VID_PRIO) begin
                cust_tci_nxt[VID_W-1:0] = port_default_vlan_id_in;
                vid_fix_nxt             = 1'b1;
            end
        end
    end

    logic               a_valid_r;
    logic [PORT_W-1:0]  a_port_r;
    logic               a_isp_port_r;
    logic               a_dt_r;
    logic               a_ins_isp_r;
    logic               a_ins_cust_r;
    logic [15:0]        a_isp_tci_r;
    logic [15:0]        a_cust_tci_r;
    logic               a_fix_r;
    logic               a_untagged_r;
    logic [2:0]         a_tc_r;
    logic               a_ctrl_r;
    logic [NPORT-1:0]   a_arl_r;
    logic [VID_W-1:0]   a_vid_r;
    logic [ENTRY_W-1:0] entry_r;
    logic [VID_W-1:0]   lookup_vid;

    // isp VID for lookups when double tagging, else the 802.1Q tag
    assign lookup_vid = dt_active ? isp_tci_nxt[VID_W-1:0]
                                  : cust_tci_nxt[VID_W-1:0];

    always_ff @(posedge clk_sys_in) begin
        if (!rst_n_in) begin
            a_valid_r <= 1'b0;
        end else begin
            a_valid_r <= frm_valid_in;
        end
    end

    always_ff @(posedge clk_sys_in) begin
        entry_r      <= vtable[lookup_vid];
        a_port_r     <= frm_port_in;
        a_isp_port_r <= is_isp_port;
        a_dt_r       <= dt_active;
        a_ins_isp_r  <= ins_isp_nxt;
        a_ins_cust_r <= ins_cust_nxt;
        a_isp_tci_r  <= isp_tci_nxt;
        a_cust_tci_r <= cust_tci_nxt;
        a_fix_r      <= vid_fix_nxt;
        a_untagged_r <= (frm_tag_count_in == 2'h0);
        a_tc_r       <= tc_nxt;
        a_ctrl_r     <= frm_control_in;
        a_arl_r      <= arl_fwd_vec_in;
        a_vid_r      <= lookup_vid;
    end

    // ********************************************
    // stage B: forwarding decision
    // ********************************************
    logic [NPORT-1:0] memb;
    logic [NPORT-1:0] untag;
    logic             fwd_src;
    logic [NPORT-1:0] sel_vec;
    logic [NPORT-1:0] dest_nxt;
    logic [NPORT-1:0] untag_nxt;
    logic [NPORT-1:0] cpu_bit;
    logic             to_cpu;

    assign memb    = entry_r[NPORT-1:0];
    assign untag   = entry_r[E_FWD-1:E_UNTAG_LO];
    assign fwd_src = entry_r[E_FWD];
    assign cpu_bit = NPORT'(1) << CPU_PORT;
    assign to_cpu  = mgmt_mode && !reserved_multicast_flood && a_ctrl_r;

    always_comb begin
        sel_vec = a_arl_r;
        if (fwd_src && (a_isp_port_r || !a_dt_r)) begin
            sel_vec = memb;
        end
        if (a_dt_r && pvlan_en) begin
            sel_vec = a_arl_r;
        end
        dest_nxt = sel_vec & port_mask_r[a_port_r];
        if (a_dt_r && to_cpu) begin
            dest_nxt = cpu_bit;
        end
        untag_nxt = untag;
        if (mgmt_mode) begin
            untag_nxt = untag & ~cpu_bit;
        end
    end

    always_ff @(posedge clk_sys_in) begin
        if (!rst_n_in) begin
            res_valid_out <= 1'b0;
        end else begin
            res_valid_out <= a_valid_r;
        end
    end

    always_ff @(posedge clk_sys_in) begin
        if (!rst_n_in) begin
            res_dest_vec_out    <= '0;
            res_untag_vec_out   <= '0;
            res_vlan_id_out     <= '0;
            traffic_class_out   <= '0;
            res_insert_isp_out  <= 1'b0;
            res_insert_cust_out <= 1'b0;
            res_isp_tci_out     <= '0;
            res_cust_tci_out    <= '0;
            res_fcs_regen_out   <= 1'b0;
        end else if (a_valid_r) begin
            res_dest_vec_out    <= dest_nxt;
            res_untag_vec_out   <= untag_nxt;
            res_vlan_id_out     <= a_vid_r;
            traffic_class_out   <= a_tc_r;
            res_insert_isp_out  <= a_ins_isp_r;
            res_insert_cust_out <= a_ins_cust_r;
            res_isp_tci_out     <= a_isp_tci_r;
            res_cust_tci_out    <= a_cust_tci_r;
            res_fcs_regen_out   <= a_ins_isp_r || a_ins_cust_r || a_fix_r
                                   || (|(dest_nxt & untag_nxt) && !a_untagged_r)
                                   || (|(dest_nxt & ~untag_nxt) && a_untagged_r);
        end
    end

    // ********************************************
    // checks
    // ********************************************
    a_dest_masked: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
        frm_valid_in && !dt_active ##2 res_valid_out
        |-> (res_dest_vec_out & ~$past(port_mask_r[frm_port_in], 2)) == '0)
        else $error("destination outside permitted ports");
    a_valid_latency: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
        frm_valid_in |-> ##2 res_valid_out)
        else $error("result not two cycles after descriptor");
    a_mgmt_keeps_tag: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
        res_valid_out && mgmt_mode && $stable(global_r) |-> !res_untag_vec_out[CPU_PORT])
        else $error("management port tag stripped");
    a_dt_off_plain: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
        frm_valid_in && !dt_active |-> ##2 !res_insert_isp_out && !res_insert_cust_out)
        else $error("tag inserted with double tagging off");
    a_isp_untag_both: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
        frm_valid_in && dt_active && is_isp_port && !outer_isp
        |-> ##2 res_insert_isp_out && res_insert_cust_out)
        else $error("isp port frame not given both tags");
    a_isp_keep_double: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
        frm_valid_in && dt_active && outer_isp && frm_tag_count_in == 2'h2
        |-> ##2 !res_insert_isp_out && !res_insert_cust_out)
        else $error("double-tagged frame was renormalised");
    a_port_default_vlan_id_insert: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
        frm_valid_in && dt_active && !outer_isp
        |-> ##2 res_isp_tci_out[VID_W-1:0] == $past(port_default_vlan_id_in, 2))
        else $error("inserted isp VID differs from port default");
    a_class_kept: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
        frm_valid_in && frm_tag_count_in != 2'h0
        |-> ##2 traffic_class_out == $past(frm_outer_tci_in[15:13], 2))
        else $error("traffic class changed");
    a_insert_fcs: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
        res_valid_out && (res_insert_isp_out || res_insert_cust_out) |-> res_fcs_regen_out)
        else $error("tag inserted without check-sequence regeneration");
endmodule : vlan_double_tag_filter
`default_nettype wire

// ### vlan_dtag_pkg.sv
/*
 * Constants for the VLAN filter and double-tag normalisation stage:
 * register offsets, field positions, reset values and table sizes.
 * Assumes a six-port switch, port 5 being the processor port.
 */
package vlan_dtag_pkg;
    // ********************************************
    // sizes
    // ********************************************
    localparam int NPORT     = 6;
    localparam int PORT_W    = 3;
    localparam int VID_W     = 12;
    localparam int VT_DEPTH  = 4096;
    localparam int ENTRY_W   = 2 * NPORT + 1;
    localparam logic [PORT_W-1:0] CPU_PORT = 3'h5;
    // ********************************************
    // tag constants
    // ********************************************
    localparam logic [15:0] TAG_PROTOCOL_IDENTIFIER_CUST     = 16'h8100;
    localparam logic [15:0] TAG_PROTOCOL_IDENTIFIER_ISP_RST  = 16'h9100;
    localparam logic [VID_W-1:0] VID_PRIO = 12'h000;
    // ********************************************
    // register offsets (byte addresses)
    // ********************************************
    localparam logic [7:0] REG_GLOBAL    = 8'h00;
    localparam logic [7:0] REG_ISP_TAG_PROTOCOL_IDENTIFIER  = 8'h04;
    localparam logic [7:0] REG_ISP_PORTS = 8'h08;
    localparam logic [7:0] REG_VT_INDEX  = 8'h0C;
    localparam logic [7:0] REG_VT_DATA   = 8'h10;
    localparam logic [7:0] REG_FRM_COUNT = 8'h14;
    localparam logic [7:0] REG_PORT_BASE = 8'h18;
    localparam logic [7:0] REG_PORT_STEP = 8'h04;
    // ********************************************
    // field positions
    // ********************************************
    localparam int G_MGMT    = 0;
    localparam int G_RMFLOOD = 1;
    localparam int G_DT_LO   = 2;
    localparam int G_PVLAN   = 4;
    localparam int G_QEN     = 7;
    localparam int PC_MASK_LO = 16;
    localparam int VD_UNTAG_LO = 8;
    localparam int VD_FWD      = 16;
    localparam int E_UNTAG_LO  = NPORT;
    localparam int E_FWD       = 2 * NPORT;
    // ********************************************
    // reset values
    // ********************************************
    localparam logic [7:0]       GLOBAL_RST    = 8'h00;
    localparam logic [NPORT-1:0] PORT_MASK_RST = 6'h3F;
    localparam logic [VID_W-1:0] PORT_DEFAULT_VLAN_ID_RST      = 12'h001;
endpackage : vlan_dtag_pkg
